// ==== src/sts_bus_sync.sv ====
`timescale 1ns/1ns
module sts_bus_sync (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Raw pins
  input  wire logic [11:0] rawIn,
  // Synchronised
  output logic [11:0]      syncOut
);
  logic [11:0] stage1_ff;
  logic [11:0] stage2_ff;

  // Two flops; bus idles high so reset to ones
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_ff <= 12'hFFF;
      stage2_ff <= 12'hFFF;
    end else begin
      stage1_ff <= rawIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule : sts_bus_sync

// ==== src/sts_defines.svh ====
`ifndef STS_DEFINES_SVH
`define STS_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define STS_CLK_PERIOD_NS   50
`define STS_POR_MS          110
`define STS_POR_CYCLES      ((`STS_POR_MS * 1000000) / `STS_CLK_PERIOD_NS)
`define STS_SETUP_NS        125
`define STS_SETUP_CYCLES    \
  ((`STS_SETUP_NS + `STS_CLK_PERIOD_NS - 1) / `STS_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Phase encodings {ioLine, cdLine, msgLine}
// ----------------------------------------------------------------
`define STS_PH_CMD          3'b101
`define STS_PH_DATA_IN      3'b111
`define STS_PH_DATA_OUT     3'b011
`define STS_PH_STATUS       3'b001
`define STS_PH_MESSAGE      3'b000
`define STS_PH_IDLE         3'b111

// ----------------------------------------------------------------
// Command block
// ----------------------------------------------------------------
`define STS_CMD_BYTES       6
`define STS_DEF_ADDR        8'hFE
`define STS_MSG_BYTE        8'h00
`define STS_LUN_MAX         3'h1

`endif

// ==== src/sts_pkg.sv ====
package sts_pkg;

  typedef enum logic [2:0] {
    ST_FREE,
    ST_SELECT,
    ST_SETUP,
    ST_REQ,
    ST_WAIT_ACK_HI,
    ST_RELEASE
  } sts_state_t;

  typedef enum logic [2:0] {
    PH_CMD,
    PH_DATA_IN,
    PH_DATA_OUT,
    PH_STATUS,
    PH_MESSAGE
  } sts_phase_t;

  // Decoded command block
  typedef struct packed {
    logic [7:0]  opcode;
    logic [2:0]  lun;
    logic [20:0] sector;
    logic [7:0]  count;
    logic [7:0]  control;
  } sts_cmd_t;

  // Back-end job request after the command block
  typedef struct packed {
    logic        toHost;
    logic [9:0]  blockLen;
    logic [7:0]  blockNum;
  } sts_job_t;

endpackage : sts_pkg

// ==== src/sts_target_seq.sv ====
`timescale 1ns/1ns
`include "sts_defines.svh"

// Function
// - Bus reset restores power-on state, 110 ms
// - Reset anytime, then bus free
// - Bus free leaves all control lines high
// - Address plus SEL low, target answers BUSY
// - Answer only own one-low address
// - Set phase lines before each transfer
// - Command six bytes, status, message encodings
// - Data from host lengths 3..516
// - Data to host lengths 1..516
// - Four-step REQ/ACK interlock per byte
// - Data stable 125 ns before REQ low
// - Byte valid at REQ rising edge
// - Status byte reports error and drive
// - Message byte is all zeros
// - BUSY rising ends the transaction
// - Select, command, data, status, message, release
// - All data blocks same direction, size
// - Command byte layout of six bytes
// - Byte 0 first, opcode per command
// - I/O low means toward host
// - Unit in upper three bits, 0 or 1
// - Sector address 21 bits from bytes 1-3
module sts_target_seq #(
  parameter int unsigned PorCycles = `STS_POR_CYCLES
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  // Host bus pins, active low
  input  wire logic [7:0]      busDataIn,
  output logic [7:0]           busDataOut,
  output logic                 busDataOe_b,
  input  wire logic            busSel_b,
  input  wire logic            busAck_b,
  input  wire logic            busRst_b,
  output logic                 busBusy_b,
  output logic                 busReq_b,
  output logic                 busCd_b,
  output logic                 busMsg_b,
  output logic                 busIo_b,
  // Configuration
  input  wire logic [7:0]      ownAddr,
  // Back end
  output sts_pkg::sts_cmd_t    cmdOut,
  output logic                 cmdValid,
  input  wire sts_pkg::sts_job_t jobIn,
  input  wire logic            jobValid,
  input  wire logic [7:0]      txByte,
  output logic [7:0]           rxByte,
  output logic                 byteStrobe,
  input  wire logic            statusError,
  input  wire logic            statusDrive,
  output logic                 portReady
);
  import sts_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sts_state_t  st;
    sts_phase_t  ph;
    logic [21:0] porCnt;
    logic [2:0]  setupCnt;
    logic [9:0]  byteCnt;
    logic [9:0]  blockLen;
    logic [7:0]  blocksLeft;
    logic        toHost;
    logic [47:0] cmdBuf;
    logic [7:0]  dOut;
    logic        dOe_b;
    logic        busy_b;
    logic        req_b;
    logic [2:0]  lines;
    logic        cmdV;
    logic [7:0]  rx;
    logic        strobe;
    logic        ready;
    logic        lunBad;
  } sts_regs_t;

  sts_regs_t   r_ff;
  sts_regs_t   nxt_r;
  logic [11:0] syncBus;
  logic [7:0]  dSync;
  logic        selS_b;
  logic        ackS_b;
  logic        rstS_b;
  logic        addrHit;

  // Bus inputs come from the host, not our clock
  sts_bus_sync u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .rawIn   ({1'b1, busRst_b, busAck_b, busSel_b, busDataIn}),
    .syncOut (syncBus)
  );

  assign dSync  = syncBus[7:0];
  assign selS_b = syncBus[8];
  assign ackS_b = syncBus[9];
  assign rstS_b = syncBus[10];

  // Exactly one bit low and it matches ours
  always_comb begin
    addrHit = (dSync == ownAddr) && ($countones(~ownAddr) == 1);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r        = r_ff;
    nxt_r.cmdV   = 1'b0;
    nxt_r.strobe = 1'b0;
    if (!rstS_b || r_ff.porCnt != '0) begin
      // Held in power-on state for the whole window
      nxt_r        = '0;
      nxt_r.st     = ST_FREE;
      nxt_r.ph     = PH_CMD;
      nxt_r.dOe_b  = 1'b1;
      nxt_r.busy_b = 1'b1;
      nxt_r.req_b  = 1'b1;
      nxt_r.lines  = `STS_PH_IDLE;
      nxt_r.porCnt = !rstS_b ? PorCycles[21:0] : r_ff.porCnt - 22'h1;
    end else begin
      unique case (r_ff.st)
        ST_FREE: begin
          nxt_r.ready = 1'b1;
          if (!selS_b && addrHit) begin
            nxt_r.busy_b  = 1'b0;
            nxt_r.ready   = 1'b0;
            nxt_r.st      = ST_SELECT;
          end
        end
        ST_SELECT: begin
          // Wait for SEL release before driving phases
          if (selS_b) begin
            nxt_r.ph       = PH_CMD;
            nxt_r.lines    = `STS_PH_CMD;
            nxt_r.byteCnt  = 10'h0;
            nxt_r.setupCnt = 3'h0;
            nxt_r.st       = ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Data held a full setup window before REQ falls
          if (r_ff.setupCnt >= 3'(`STS_SETUP_CYCLES)) begin
            nxt_r.req_b = 1'b0;
            nxt_r.st    = ST_REQ;
          end else begin
            nxt_r.setupCnt = r_ff.setupCnt + 3'h1;
          end
        end
        ST_REQ: begin
          if (!ackS_b) begin
            // Data and ACK pass the same two-flop sync, so they stay aligned
            nxt_r.rx     = dSync;
            nxt_r.req_b  = 1'b1;
            nxt_r.strobe = 1'b1;
            nxt_r.st     = ST_WAIT_ACK_HI;
            if (r_ff.ph == PH_CMD) begin
              // Byte 0 lands in the top of the buffer
              nxt_r.cmdBuf = {r_ff.cmdBuf[39:0], dSync};
            end
          end
        end
        ST_WAIT_ACK_HI: begin
          if (ackS_b) begin
            nxt_r.byteCnt  = r_ff.byteCnt + 10'h1;
            nxt_r.setupCnt = 3'h0;
            nxt_r.st       = ST_SETUP;
            nxt_r.dOe_b    = 1'b1;
            unique case (r_ff.ph)
              PH_CMD: begin
                if (r_ff.byteCnt == 10'(`STS_CMD_BYTES - 1)) begin
                  nxt_r.cmdV = 1'b1;
                  nxt_r.lunBad = r_ff.cmdBuf[39:37] > `STS_LUN_MAX;
                  nxt_r.st   = ST_RELEASE; // Parked until job
                end
              end
              PH_DATA_IN, PH_DATA_OUT: begin
                if (r_ff.byteCnt == r_ff.blockLen - 10'h1) begin
                  nxt_r.byteCnt    = 10'h0;
                  nxt_r.blocksLeft = r_ff.blocksLeft - 8'h1;
                  if (r_ff.blocksLeft == 8'h1) begin
                    nxt_r.ph    = PH_STATUS;
                    nxt_r.lines = `STS_PH_STATUS;
                    nxt_r.dOut  = {6'h0, statusDrive,
                                   statusError | r_ff.lunBad};
                    nxt_r.dOe_b = 1'b0;
                  end else if (r_ff.toHost) begin
                    nxt_r.dOut  = txByte;
                    nxt_r.dOe_b = 1'b0;
                  end
                end else if (r_ff.toHost) begin
                  nxt_r.dOut  = txByte;
                  nxt_r.dOe_b = 1'b0;
                end
              end
              PH_STATUS: begin
                nxt_r.ph    = PH_MESSAGE;
                nxt_r.lines = `STS_PH_MESSAGE;
                nxt_r.dOut  = `STS_MSG_BYTE;
                nxt_r.dOe_b = 1'b0;
              end
              default: begin
                // Message sent: drop the bus
                nxt_r.lines  = `STS_PH_IDLE;
                nxt_r.busy_b = 1'b1;
                nxt_r.st     = ST_FREE;
              end
            endcase
          end
        end
        ST_RELEASE: begin
          // Back end fixes one direction and size per job
          if (jobValid) begin
            nxt_r.toHost     = jobIn.toHost;
            nxt_r.blockLen   = jobIn.blockLen;
            nxt_r.blocksLeft = jobIn.blockNum;
            nxt_r.byteCnt    = 10'h0;
            nxt_r.setupCnt   = 3'h0;
            nxt_r.st         = ST_SETUP;
            if (jobIn.blockNum == 8'h0 || jobIn.blockLen == 10'h0) begin
              nxt_r.ph    = PH_STATUS;
              nxt_r.lines = `STS_PH_STATUS;
              nxt_r.dOut  = {6'h0, statusDrive,
                             statusError | r_ff.lunBad};
              nxt_r.dOe_b = 1'b0;
            end else if (jobIn.toHost) begin
              nxt_r.ph    = PH_DATA_OUT;
              nxt_r.lines = `STS_PH_DATA_OUT;
              nxt_r.dOut  = txByte;
              nxt_r.dOe_b = 1'b0;
            end else begin
              nxt_r.ph    = PH_DATA_IN;
              nxt_r.lines = `STS_PH_DATA_IN;
            end
          end
        end
        default: nxt_r.st = ST_FREE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_ff        <= '0;
      r_ff.st     <= ST_FREE;
      r_ff.ph     <= PH_CMD;
      r_ff.porCnt <= PorCycles[21:0];
      r_ff.dOe_b  <= 1'b1;
      r_ff.busy_b <= 1'b1;
      r_ff.req_b  <= 1'b1;
      r_ff.lines  <= `STS_PH_IDLE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign busDataOut  = r_ff.dOut;
  assign busDataOe_b = r_ff.dOe_b;
  assign busBusy_b   = r_ff.busy_b;
  assign busReq_b    = r_ff.req_b;
  assign busIo_b     = r_ff.lines[2];
  assign busCd_b     = r_ff.lines[1];
  assign busMsg_b    = r_ff.lines[0];
  assign cmdOut      = '{opcode:  r_ff.cmdBuf[47:40],
                         lun:     r_ff.cmdBuf[39:37],
                         sector:  r_ff.cmdBuf[36:16],
                         count:   r_ff.cmdBuf[15:8],
                         control: r_ff.cmdBuf[7:0]};
  assign cmdValid    = r_ff.cmdV;
  assign rxByte      = r_ff.rx;
  assign byteStrobe  = r_ff.strobe;
  assign portReady   = r_ff.ready;
endmodule : sts_target_seq

// ==== testbench/sts_host_model.sv ====
`timescale 1ns/1ns
module sts_host_model (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Bench control
  input wire logic        go,
  input wire logic [7:0]  addr,
  input wire logic [71:0] hostTx,
  input wire logic [3:0]  dly,
  // Bus
  input wire logic [7:0]  busLevel,
  input wire logic        busBusy_b,
  input wire logic        busReq_b,
  input wire logic        busIo_b,
  output logic [7:0]      hostData,
  output logic            busSel_b,
  output logic            busAck_b,
  // Bytes seen
  output logic [7:0]      rxLast,
  output logic [7:0]      rxPrev,
  output logic [7:0]      rxCnt
);
  // ------------------
  // Initiator
  // ------------------
  logic [3:0] idx_ff;
  logic [3:0] wait_ff;
  // Terminated bus floats high when nobody drives it
  assign hostData = (go && busBusy_b) ? addr :
    (!busAck_b && busIo_b) ? hostTx[{idx_ff, 3'b000} +: 8] : 8'hFF;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busSel_b <= 1'b1;
      busAck_b <= 1'b1;
      idx_ff <= '0;
      wait_ff <= '0;
      rxLast <= '0;
      rxPrev <= '0;
      rxCnt <= '0;
    end else begin
      busSel_b <= !(go && busBusy_b);
      if (go && busBusy_b) begin
        idx_ff <= '0;
        rxCnt <= '0;
      end
      if (!busReq_b && busAck_b) begin
        if (wait_ff != dly) wait_ff <= wait_ff + 4'h1;
        else begin
          busAck_b <= 1'b0;
          wait_ff <= '0;
          if (!busIo_b) begin
            rxPrev <= rxLast;
            rxLast <= busLevel;
            rxCnt <= rxCnt + 8'h01;
          end
        end
      end else if (busReq_b && !busAck_b) begin
        busAck_b <= 1'b1;
        if (busIo_b) idx_ff <= idx_ff + 4'h1;
      end
    end
  end
endmodule : sts_host_model

// ==== testbench/sts_target_seq_checker.sv ====
`timescale 1ns/1ns
`include "sts_defines.svh"
module sts_target_seq_checker #(
  parameter int unsigned PorCycles = 20
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // Host bus
  input wire logic [7:0] busDataIn,
  input wire logic [7:0] busDataOut,
  input wire logic       busDataOe_b,
  input wire logic       busSel_b,
  input wire logic       busAck_b,
  input wire logic       busRst_b,
  input wire logic       busBusy_b,
  input wire logic       busReq_b,
  input wire logic       busCd_b,
  input wire logic       busMsg_b,
  input wire logic       busIo_b,
  input wire logic [7:0] ownAddr
);
  // ------------------
  // Bus rules
  // ------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [31:0] porCnt_ff;
  logic [2:0]  phase;
  assign phase = {busIo_b, busCd_b, busMsg_b};
  // Saturates so a long idle spell never wraps
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) porCnt_ff <= '0;
    else if (!busRst_b) porCnt_ff <= '0;
    else if (porCnt_ff <= PorCycles) porCnt_ff <= porCnt_ff + 1;
  end
  property p_idle;
    busBusy_b |-> &{busReq_b, busCd_b, busMsg_b, busIo_b, busDataOe_b};
  endproperty
  a_idle: assert property (p_idle) else $error("idle lines");
  property p_setup;
    $fell(busReq_b) && !busIo_b |-> !busDataOe_b && $stable(busDataOut)
      && $past(busDataOut, 2) == busDataOut;
  endproperty
  a_setup: assert property (p_setup) else $error("setup");
  property p_hold;
    $rose(busReq_b) && !busBusy_b && !busIo_b |-> $stable(busDataOut);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_hand;
    $rose(busReq_b) && !busBusy_b |-> !busAck_b && !$past(busAck_b, 2);
  endproperty
  a_hand: assert property (p_hand) else $error("handshake");
  property p_sel;
    $fell(busBusy_b) |-> !$past(busSel_b, 3) && $past(busDataIn, 3) == ownAddr;
  endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_msg;
    !busBusy_b && !busReq_b && phase == `STS_PH_MESSAGE
      |-> busDataOut == `STS_MSG_BYTE;
  endproperty
  a_msg: assert property (p_msg) else $error("message");
  property p_phase;
    !busBusy_b && !busReq_b |-> phase inside {`STS_PH_CMD, `STS_PH_DATA_IN,
      `STS_PH_DATA_OUT, `STS_PH_STATUS, `STS_PH_MESSAGE};
  endproperty
  a_phase: assert property (p_phase) else $error("phase code");
  property p_dir; !busBusy_b && !busReq_b |-> busDataOe_b == busIo_b; endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_brst; !busRst_b [*4] |-> busBusy_b && busReq_b; endproperty
  a_brst: assert property (p_brst) else $error("bus reset");
  property p_por; $fell(busBusy_b) |-> porCnt_ff >= PorCycles; endproperty
  a_por: assert property (p_por) else $error("early answer");
  c_sel: cover property ($fell(busBusy_b));
  c_msg: cover property (!busReq_b && phase == `STS_PH_MESSAGE);
  c_rst: cover property (!busRst_b && !busBusy_b);
endmodule : sts_target_seq_checker

bind sts_target_seq sts_target_seq_checker #(.PorCycles(PorCycles)) i_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .busDataIn(busDataIn),
  .busDataOut(busDataOut), .busDataOe_b(busDataOe_b), .busSel_b(busSel_b),
  .busAck_b(busAck_b), .busRst_b(busRst_b), .busBusy_b(busBusy_b),
  .busReq_b(busReq_b), .busCd_b(busCd_b), .busMsg_b(busMsg_b),
  .busIo_b(busIo_b), .ownAddr(ownAddr));

// ==== testbench/sts_target_seq_tb_top.sv ====
`timescale 1ns/1ns
`include "sts_defines.svh"
module sts_target_seq_tb_top;
  import sts_pkg::*;
  // ------------------
  // Bench
  // ------------------
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        busRst_b = 1'b1;
  logic        go = 1'b0;
  logic        stErr = 1'b0;
  logic        stDrv = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic [7:0]  addr = 8'hFF;
  logic [71:0] hostTx = '0;
  sts_job_t    jobIn = '0;
  logic [7:0]  busLevel, busDataOut, rxByte, rxLast, rxPrev, rxCnt, hostData;
  logic [7:0]  rxSeen;
  logic        busDataOe_b, busSel_b, busAck_b, busBusy_b, busReq_b;
  logic        busCd_b, busMsg_b, busIo_b, cmdValid, byteStrobe, portReady;
  sts_cmd_t    cmdOut, cmdSeen;
  int          mismatches = 0;
  int          testsRun = 0;
  int          nStb, nCmd;
  always #25 ref_clk = !ref_clk;
  assign busLevel = !busDataOe_b ? busDataOut : hostData;
  sts_target_seq #(.PorCycles(20)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .busDataIn(busLevel),
    .busDataOut(busDataOut), .busDataOe_b(busDataOe_b), .busSel_b(busSel_b),
    .busAck_b(busAck_b), .busRst_b(busRst_b), .busBusy_b(busBusy_b),
    .busReq_b(busReq_b), .busCd_b(busCd_b), .busMsg_b(busMsg_b),
    .busIo_b(busIo_b), .ownAddr(`STS_DEF_ADDR), .cmdOut(cmdOut),
    .cmdValid(cmdValid), .jobIn(jobIn), .jobValid(1'b1), .txByte(8'h5A),
    .rxByte(rxByte), .byteStrobe(byteStrobe), .statusError(stErr),
    .statusDrive(stDrv), .portReady(portReady));
  sts_host_model i_host (
    .ref_clk(ref_clk), .rst_b(rst_b), .go(go), .addr(addr), .hostTx(hostTx),
    .dly(dly), .busLevel(busLevel), .busBusy_b(busBusy_b),
    .busReq_b(busReq_b), .busIo_b(busIo_b), .hostData(hostData),
    .busSel_b(busSel_b), .busAck_b(busAck_b), .rxLast(rxLast),
    .rxPrev(rxPrev), .rxCnt(rxCnt));
  task automatic conclude();
    $display("tests %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Counts strobes of bytes from the host (I/O high) on the way so none is missed
  task automatic wait_busy(input logic want);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if (byteStrobe === 1'b1 && busIo_b === 1'b1) begin
        nStb++;
        rxSeen = rxByte;
      end
      if (cmdValid === 1'b1) begin
        nCmd++;
        cmdSeen = cmdOut;
      end
      if (n > 3000) begin
        mismatches++;
        $display("ERROR %0t: busy wait timeout", $time);
        conclude();
      end
    end while (busBusy_b !== want);
  endtask : wait_busy
  task automatic select(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    go <= 1'b1;
    nStb = 0;
    nCmd = 0;
    wait_busy(1'b0);
    @(posedge ref_clk);
    go <= 1'b0;
  endtask : select
  task automatic t_reset();
    @(negedge ref_clk);
    check({busBusy_b, busReq_b, busCd_b, busMsg_b, busIo_b}, 5'h1F);
    @(posedge ref_clk);
    addr <= `STS_DEF_ADDR;
    go <= 1'b1;
    repeat (15) @(negedge ref_clk);
    check(busBusy_b, 1'b1);
    select(`STS_DEF_ADDR);
    wait_busy(1'b1);
    @(negedge ref_clk);
    check(portReady, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_foreign();
    logic [7:0] bad [3] = '{8'hFD, 8'hFC, 8'h7F};
    foreach (bad[i]) begin
      @(posedge ref_clk);
      addr <= bad[i];
      go <= 1'b1;
      repeat (20) @(negedge ref_clk);
      check(busBusy_b, 1'b1);
      @(posedge ref_clk);
      go <= 1'b0;
    end
    $display("foreign test done");
  endtask : t_foreign
  task automatic t_xfer(input logic th, input logic [9:0] len,
      input logic [7:0] num, input logic [2:0] lun, input logic [1:0] st,
      input logic [3:0] d);
    @(posedge ref_clk);
    jobIn <= '{th, len, num};
    {stDrv, stErr} <= st;
    dly <= d;
    hostTx <= {24'hC3B2A1, 8'h80, num, 16'h5CA3, lun, 5'h15, 8'h08};
    select(`STS_DEF_ADDR);
    wait_busy(1'b1);
    check(nCmd, 1);
    check(cmdSeen.opcode, 8'h08);
    check(cmdSeen.lun, lun);
    check(cmdSeen.sector, 21'h15A35C);
    check(cmdSeen.count, num);
    check(nStb, th ? 6 : 6 + len * num);
    check(cmdSeen.control, 8'h80);
    check(rxSeen, (th || num == 0) ? 8'h80 : 8'hC3);
    check(rxByte, `STS_MSG_BYTE);
    check(rxCnt, th ? len * num + 2 : 2);
    check(rxPrev, {6'h00, st[1], st[0] | (lun > 3'd1)});
    check(rxLast, `STS_MSG_BYTE);
    @(negedge ref_clk);
    check(portReady, 1'b1);
    $display("transfer test done");
  endtask : t_xfer
  task automatic t_busrst();
    @(posedge ref_clk);
    jobIn <= '{1'b0, 10'd3, 8'd1};
    select(`STS_DEF_ADDR);
    repeat (12) @(posedge ref_clk);
    busRst_b <= 1'b0;
    repeat (2000) @(negedge ref_clk);
    check({busBusy_b, busReq_b, busDataOe_b}, 3'h7);
    @(posedge ref_clk);
    busRst_b <= 1'b1;
    $display("bus reset test done");
  endtask : t_busrst
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_foreign();
    t_xfer(1'b1, 10'd1, 8'd2, 3'd0, 2'b01, 4'd0);
    t_xfer(1'b0, 10'd3, 8'd1, 3'd1, 2'b10, 4'd5);
    t_xfer(1'b1, 10'd1, 8'd0, 3'd2, 2'b00, 4'd0);
    t_busrst();
    t_xfer(1'b0, 10'd3, 8'd1, 3'd0, 2'b00, 4'd1);
    conclude();
  end
endmodule : sts_target_seq_tb_top
